// File: rtl/flash_front_pkg.sv
package flash_front_pkg;

	// Framing of a command on the serial link
	localparam int          OP_BITS     = 8;
	localparam int          ADDR_BITS   = 24;
	localparam int          FRAME_BITS  = 32;
	localparam int          CNT_W       = 6;
	localparam int          PAGE_LSB    = 9;
	localparam int          PAGE_W      = 12;
	localparam int          BYTE_W      = 9;
	localparam int          DUMMY_W     = 3;

	// Address layouts: page bits, byte/buffer bits, rest are dummy
	localparam logic [23:0] MASK_PAGE12 = 24'h1F_FE00;
	localparam logic [23:0] MASK_PAGE9  = 24'h1F_F000;
	localparam logic [23:0] MASK_PAGE4  = 24'h1E_0000;
	localparam logic [23:0] MASK_BYTE9  = 24'h00_01FF;
	localparam logic [23:0] MASK_NONE   = 24'h00_0000;

	// The one opcode that makes the serial output drive
	localparam logic [7:0]  OPC_STATUS  = 8'hD7;

	// Reset values
	localparam logic        MODE3_RST   = 1'b1;
	localparam logic        CS_SYNC_RST = 1'b0;

	// Timing
	localparam int          CLK_FREQ_KHZ                  = 100_000;
	localparam int          POWERUP_PROGRAM_ERASE_WAIT_MS = 3;
	localparam int          POWERUP_PROGRAM_ERASE_CYCLES  =
		POWERUP_PROGRAM_ERASE_WAIT_MS * CLK_FREQ_KHZ;

	typedef enum logic [1:0] {
		ST_POR,
		ST_STANDBY,
		ST_CMD,
		ST_DATA
	} front_state_t;

endpackage

// File: rtl/addr_class_if.sv
`timescale 1ns/1ps
interface addr_class_if;
	logic [7:0]  opcode;
	logic [23:0] addr;
	logic        has_addr;
	logic [23:0] page_mask;
	logic [23:0] byte_mask;
	logic [2:0]  dummy_bytes;

	modport front (output opcode, output addr,
		input has_addr, input page_mask, input byte_mask, input dummy_bytes);
	modport cls (input opcode, input addr,
		output has_addr, output page_mask, output byte_mask, output dummy_bytes);
endinterface

// File: rtl/addr_classify.sv
`timescale 1ns/1ps
module addr_classify
	import flash_front_pkg::*;
(
	addr_class_if.cls c
);

	always_comb begin
		c.has_addr    = 1'b1;
		c.page_mask   = MASK_NONE;
		c.byte_mask   = MASK_NONE;
		c.dummy_bytes = 3'h0;
		case (c.opcode)
		8'h01, 8'h02, 8'h03, 8'h58, 8'h59, 8'h82, 8'h85: begin
			c.page_mask = MASK_PAGE12;
			c.byte_mask = MASK_BYTE9;
		end
		8'h0B: begin
			c.page_mask   = MASK_PAGE12;
			c.byte_mask   = MASK_BYTE9;
			c.dummy_bytes = 3'h1;
		end
		8'h1B: begin
			c.page_mask   = MASK_PAGE12;
			c.byte_mask   = MASK_BYTE9;
			c.dummy_bytes = 3'h2;
		end
		8'hD2: begin
			c.page_mask   = MASK_PAGE12;
			c.byte_mask   = MASK_BYTE9;
			c.dummy_bytes = 3'h4;
		end
		8'h53, 8'h55, 8'h60, 8'h61, 8'h81, 8'h83, 8'h86, 8'h88, 8'h89: begin
			c.page_mask = MASK_PAGE12;
		end
		8'h50: begin
			c.page_mask = MASK_PAGE9;
		end
		8'h7C: begin
			c.page_mask = MASK_PAGE4;
		end
		8'h84, 8'h87, 8'hD1, 8'hD3: begin
			c.byte_mask = MASK_BYTE9;
		end
		8'hD4, 8'hD6: begin
			c.byte_mask   = MASK_BYTE9;
			c.dummy_bytes = 3'h1;
		end
		8'h32, 8'h35, 8'h77: begin
			c.has_addr = 1'b1;
		end
		default: begin
			// Opcode-only commands and unknown codes carry no address
			c.has_addr = 1'b0;
		end
		endcase
	end

endmodule

// File: rtl/flash_spi_front.sv
`timescale 1ns/1ps
module flash_spi_front
	import flash_front_pkg::*;
#(
	parameter int unsigned    PE_WAIT_CYCLES = POWERUP_PROGRAM_ERASE_CYCLES,
	parameter logic [7:0]     STATUS_BASE    = 8'h00
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic         por_active_i,
	input  wire logic         cs_n_i,
	input  wire logic         sck_i,
	input  wire logic         si_i,
	output logic              so_o,
	output logic              so_oe_o,
	output logic              spi_mode3_o,
	output logic              standby_o,
	output logic              pe_ready_o,
	output logic              cmd_valid_o,
	output logic [7:0]        opcode_o,
	output logic [23:0]       addr_o,
	output logic              has_addr_o,
	output logic [23:0]       page_mask_o,
	output logic [23:0]       byte_mask_o,
	output logic [11:0]       page_addr_o,
	output logic [8:0]        byte_addr_o,
	output logic [2:0]        dummy_bytes_o
);
	import flash_front_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and input synchronisers

	logic rst_q1;
	logic rst_n;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end

	// Chip select syncs to low so a select held low at release is no edge
	logic cs_q1, cs_s2, cs_prev;
	logic sck_q1, sck_s2, sck_prev;
	logic si_q1, si_s2;
	logic por_q1, por_s;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cs_q1    <= CS_SYNC_RST;
			cs_s2    <= CS_SYNC_RST;
			cs_prev  <= CS_SYNC_RST;
			sck_q1   <= 1'b0;
			sck_s2   <= 1'b0;
			sck_prev <= 1'b0;
			si_q1    <= 1'b0;
			si_s2    <= 1'b0;
			por_q1   <= 1'b1;
			por_s    <= 1'b1;
		end else begin
			cs_q1    <= cs_n_i;
			cs_s2    <= cs_q1;
			cs_prev  <= cs_s2;
			sck_q1   <= sck_i;
			sck_s2   <= sck_q1;
			sck_prev <= sck_s2;
			si_q1    <= si_i;
			si_s2    <= si_q1;
			por_q1   <= por_active_i;
			por_s    <= por_q1;
		end
	end

	logic cs_fall, sck_rise, sck_fall;
	assign cs_fall  = cs_prev && !cs_s2;
	assign sck_rise = !sck_prev && sck_s2;
	assign sck_fall = sck_prev && !sck_s2;

	////////////////////////////////////////////////////////////////////////////////
	// Command shift register and classification

	front_state_t     state;
	logic [31:0]      shreg;
	logic [CNT_W-1:0] bit_cnt;
	logic [31:0]      next_shreg;
	logic             op_done, frame_done, done;

	addr_class_if cls_bus ();
	addr_classify u_classify (.c(cls_bus));

	assign next_shreg     = {shreg[30:0], si_s2};
	assign cls_bus.opcode = (bit_cnt == CNT_W'(OP_BITS - 1)) ? next_shreg[7:0]
		: next_shreg[31:24];
	assign cls_bus.addr   = next_shreg[23:0];
	assign op_done        = bit_cnt == CNT_W'(OP_BITS - 1) && !cls_bus.has_addr;
	assign frame_done     = bit_cnt == CNT_W'(FRAME_BITS - 1);
	assign done           = state == ST_CMD && !cs_s2 && !por_s && sck_rise && (op_done || frame_done);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			shreg   <= 32'h0000_0000;
			bit_cnt <= '0;
		end else if (state != ST_CMD || cs_s2) begin
			shreg   <= 32'h0000_0000;
			bit_cnt <= '0;
		end else if (sck_rise) begin
			shreg   <= next_shreg;
			bit_cnt <= bit_cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cmd_valid_o   <= 1'b0;
			opcode_o      <= 8'h00;
			addr_o        <= 24'h00_0000;
			has_addr_o    <= 1'b0;
			page_mask_o   <= MASK_NONE;
			byte_mask_o   <= MASK_NONE;
			page_addr_o   <= 12'h000;
			byte_addr_o   <= 9'h000;
			dummy_bytes_o <= 3'h0;
		end else begin
			cmd_valid_o <= done;
			if (done) begin
				opcode_o      <= cls_bus.opcode;
				addr_o        <= op_done ? 24'h00_0000 : cls_bus.addr;
				has_addr_o    <= cls_bus.has_addr;
				page_mask_o   <= cls_bus.page_mask;
				byte_mask_o   <= cls_bus.byte_mask;
				page_addr_o   <= cls_bus.addr[PAGE_LSB +: PAGE_W]
					& cls_bus.page_mask[PAGE_LSB +: PAGE_W];
				byte_addr_o   <= cls_bus.addr[BYTE_W-1:0] & cls_bus.byte_mask[BYTE_W-1:0];
				dummy_bytes_o <= cls_bus.dummy_bytes;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frame control, mode selection and serial output

	logic [7:0] out_sh;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state       <= ST_POR;
			spi_mode3_o <= MODE3_RST;
			standby_o   <= 1'b0;
			so_oe_o     <= 1'b0;
		end else if (por_s) begin
			state       <= ST_POR;
			spi_mode3_o <= MODE3_RST;
			standby_o   <= 1'b0;
			so_oe_o     <= 1'b0;
		end else if (cs_s2) begin
			// Select must be seen high before any command can start
			state     <= ST_STANDBY;
			standby_o <= 1'b1;
			so_oe_o   <= 1'b0;
		end else begin
			case (state)
			ST_STANDBY: begin
				if (cs_fall) begin
					state       <= ST_CMD;
					spi_mode3_o <= sck_s2;
					standby_o   <= 1'b0;
				end
			end
			ST_CMD: begin
				if (done) begin
					state   <= ST_DATA;
					so_oe_o <= cls_bus.opcode == OPC_STATUS;
				end
			end
			ST_DATA: begin
				state <= ST_DATA;
			end
			default: begin
				// Stays put until select rises; a low select at release is no frame
				state <= state;
			end
			endcase
		end
	end

	// Output changes on falling clock so the host samples it on the rising one
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			out_sh <= 8'h00;
			so_o   <= 1'b0;
		end else if (done) begin
			out_sh <= {pe_ready_o, STATUS_BASE[6:0]};
		end else if (state == ST_DATA && so_oe_o && sck_fall) begin
			so_o   <= out_sh[7];
			out_sh <= {out_sh[6:0], out_sh[7]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power-up delay before the first program or erase

	logic [31:0] pe_cnt;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pe_cnt     <= 32'h0000_0000;
			pe_ready_o <= 1'b0;
		end else if (por_s) begin
			pe_cnt     <= 32'h0000_0000;
			pe_ready_o <= 1'b0;
		end else if (!pe_ready_o) begin
			if (pe_cnt == PE_WAIT_CYCLES - 1) begin
				pe_ready_o <= 1'b1;
			end else begin
				pe_cnt <= pe_cnt + 32'h0000_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	property p_mode_after_por;
		(state == ST_POR) |=> spi_mode3_o;
	endproperty
	a_mode_after_por: assert property (p_mode_after_por)
		else $error("mode not 3 after power-on reset");

	property p_so_quiet;
		so_oe_o |-> (state == ST_DATA && opcode_o == OPC_STATUS);
	endproperty
	a_so_quiet: assert property (p_so_quiet)
		else $error("serial output driven without status command");

	property p_start_on_fall;
		(state == ST_STANDBY && !cs_fall) |=> state != ST_CMD;
	endproperty
	a_start_on_fall: assert property (p_start_on_fall)
		else $error("command started without select fall");

	property p_mode_sample;
		(state == ST_STANDBY && cs_fall && !cs_s2 && !por_s) |=>
			(spi_mode3_o == $past(sck_s2) && state == ST_CMD);
	endproperty
	a_mode_sample: assert property (p_mode_sample)
		else $error("clock mode not taken from idle clock");

	property p_por_ignores;
		por_s |=> (state == ST_POR && !standby_o) ##1 !cmd_valid_o;
	endproperty
	a_por_ignores: assert property (p_por_ignores)
		else $error("activity during power-on reset");

	property p_standby;
		(!por_s && cs_s2) |=> (standby_o && state == ST_STANDBY);
	endproperty
	a_standby: assert property (p_standby)
		else $error("not in standby with select high");

	property p_pe_delay;
		$rose(pe_ready_o) |-> $past(pe_cnt) == PE_WAIT_CYCLES - 1;
	endproperty
	a_pe_delay: assert property (p_pe_delay)
		else $error("program/erase ready at wrong time");

	property p_page_class;
		(cmd_valid_o && opcode_o == 8'h50) |->
			(page_mask_o == MASK_PAGE9 && byte_mask_o == MASK_NONE);
	endproperty
	a_page_class: assert property (p_page_class)
		else $error("wrong address classes for page compare");

	property p_drop_partial;
		(state == ST_CMD && cs_s2) |=> bit_cnt == '0 ##1 !cmd_valid_o;
	endproperty
	a_drop_partial: assert property (p_drop_partial)
		else $error("partial command survived select rise");

	c_addr_cmd: cover property (cmd_valid_o && has_addr_o);
	c_status:   cover property (so_oe_o && sck_fall);
	c_mode0:    cover property (state == ST_CMD && !spi_mode3_o);

endmodule

// File: test/spi_host.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module spi_host (
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      si_o,
	input  wire logic so_i
);
	bit ready = 1'b0;
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b1;
		si_o = 1'b0;
		// Select held off after supply is good
		#70_000 ready = 1'b1;
	end
	task automatic open_frame(input logic idle);
		wait (ready);
		sck_o = idle;
		#62.5 cs_n_o = 1'b0;
		#62.5;
	endtask
	task automatic xfer(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			sck_o = 1'b0;
			si_o = b[i];
			#62.5 sck_o = 1'b1;
			r[i] = so_i;
			#62.5;
		end
	endtask
	task automatic close_frame(input logic idle);
		sck_o = idle;
		// Released data line must not look held
		si_o = ~si_o;
		#62.5 cs_n_o = 1'b1;
		#500;
	endtask
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import flash_front_pkg::*;
	typedef struct packed {
		logic [7:0]  op;
		logic        idle;
		logic        has;
		logic [23:0] pm;
		logic [23:0] bm;
		logic [2:0]  dum;
	} row_t;
	localparam logic [23:0] ADR  = 24'hED_B5A3;
	localparam logic [7:0]  STAT = 8'h35;
	localparam logic [23:0] P12 = 24'h1F_FE00;
	localparam logic [23:0] B9  = 24'h00_01FF;
	row_t rows [13] = '{
		'{8'h03, 1'b1, 1'b1, P12, B9, 3'h0}, '{8'h0B, 1'b0, 1'b1, P12, B9, 3'h1},
		'{8'h1B, 1'b1, 1'b1, P12, B9, 3'h2}, '{8'hD2, 1'b0, 1'b1, P12, B9, 3'h4},
		'{8'h50, 1'b1, 1'b1, 24'h1F_F000, 24'h0, 3'h0},
		'{8'h7C, 1'b0, 1'b1, 24'h1E_0000, 24'h0, 3'h0},
		'{8'h84, 1'b1, 1'b1, 24'h0, B9, 3'h0}, '{8'h32, 1'b0, 1'b1, 24'h0, 24'h0, 3'h0},
		'{8'h58, 1'b1, 1'b1, P12, B9, 3'h0}, '{8'h9F, 1'b0, 1'b0, 24'h0, 24'h0, 3'h0},
		'{8'h53, 1'b1, 1'b1, P12, 24'h0, 3'h0}, '{8'hD4, 1'b0, 1'b1, 24'h0, B9, 3'h1},
		'{8'h77, 1'b1, 1'b1, 24'h0, 24'h0, 3'h0}};
	logic clk_i;
	logic resetn_i;
	logic por_active_i;
	logic cs_n, sck, si, so_o, so_oe_o, spi_mode3_o, standby_o, pe_ready_o, cmd_valid_o;
	logic has_addr_o;
	logic [7:0] opcode_o, rd;
	logic [23:0] addr_o, page_mask_o, byte_mask_o, ea;
	logic [11:0] page_addr_o;
	logic [8:0] byte_addr_o;
	logic [2:0] dummy_bytes_o;
	wire so_line = so_oe_o ? so_o : 1'bz;
	int failures = 0;
	int n_checks = 0;
	int n_cmd = 0;
	int c0;
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) if (cmd_valid_o === 1'b1) n_cmd <= n_cmd + 1;
	spi_host host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so_line));
	flash_spi_front #(.PE_WAIT_CYCLES(50), .STATUS_BASE(STAT)) i_dut (
		.clk_i(clk_i), .resetn_i(resetn_i), .por_active_i(por_active_i),
		.cs_n_i(cs_n), .sck_i(sck), .si_i(si), .so_o(so_o), .so_oe_o(so_oe_o),
		.spi_mode3_o(spi_mode3_o), .standby_o(standby_o), .pe_ready_o(pe_ready_o),
		.cmd_valid_o(cmd_valid_o), .opcode_o(opcode_o), .addr_o(addr_o),
		.has_addr_o(has_addr_o), .page_mask_o(page_mask_o), .byte_mask_o(byte_mask_o),
		.page_addr_o(page_addr_o), .byte_addr_o(byte_addr_o),
		.dummy_bytes_o(dummy_bytes_o));
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		resetn_i = 1'b0;
		por_active_i = 1'b1;
		cyc(10);
		check("mode_rst", spi_mode3_o, 1'b1);
		check("oe_rst", so_oe_o, 1'b0);
		check("stby_rst", standby_o, 1'b0);
		check("pe_rst", pe_ready_o, 1'b0);
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		// Commands while power-on reset holds are dropped
		host.open_frame(1'b1);
		host.xfer(8'h9F, rd);
		host.close_frame(1'b1);
		check("cmd_por", n_cmd, 0);
		check("stby_por", standby_o, 1'b0);
		@(posedge clk_i) por_active_i <= 1'b0;
		cyc(10);
		check("standby", standby_o, 1'b1);
		check("pe_early", pe_ready_o, 1'b0);
		cyc(50);
		check("pe_ready", pe_ready_o, 1'b1);
		foreach (rows[k]) begin
			c0 = n_cmd;
			host.open_frame(rows[k].idle);
			check("mode", spi_mode3_o, rows[k].idle);
			host.xfer(rows[k].op, rd);
			if (rows[k].has)
				for (int j = 2; j >= 0; j--) host.xfer(ADR[8*j +: 8], rd);
			ea = rows[k].has ? ADR : 24'h0;
			check("cmds", n_cmd, c0 + 1);
			check("opcode", opcode_o, rows[k].op);
			check("has", has_addr_o, rows[k].has);
			check("addr", addr_o, ea);
			check("pmask", page_mask_o, rows[k].pm);
			check("bmask", byte_mask_o, rows[k].bm);
			check("paddr", page_addr_o, (ea & rows[k].pm) >> 9);
			check("baddr", byte_addr_o, ea[8:0] & rows[k].bm[8:0]);
			check("dummy", dummy_bytes_o, rows[k].dum);
			check("oe_idle", so_oe_o, 1'b0);
			host.close_frame(rows[k].idle);
		end
		// Clocking with select high, then a dropped partial frame
		c0 = n_cmd;
		host.xfer(8'hD7, rd);
		host.open_frame(1'b1);
		host.xfer(8'h03, rd);
		host.close_frame(1'b1);
		check("cmd_hi", n_cmd, c0);
		host.open_frame(1'b1);
		host.xfer(8'h9F, rd);
		host.close_frame(1'b1);
		check("op_new", opcode_o, 8'h9F);
		host.open_frame(1'b0);
		host.xfer(8'hD7, rd);
		host.xfer(8'h00, rd);
		check("status", rd, {1'b1, STAT[6:0]});
		check("oe_on", so_oe_o, 1'b1);
		host.close_frame(1'b0);
		check("oe_off", so_oe_o, 1'b0);
		// Reset in mid-frame: mode returns and the frame is refused
		c0 = n_cmd;
		host.open_frame(1'b0);
		check("mode0", spi_mode3_o, 1'b0);
		@(posedge clk_i) resetn_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		cyc(4);
		check("mode_rel", spi_mode3_o, 1'b1);
		check("oe_rel", so_oe_o, 1'b0);
		check("pe_rel", pe_ready_o, 1'b0);
		host.xfer(8'h9F, rd);
		host.close_frame(1'b0);
		check("cmd_rel", n_cmd, c0);
		check("stby_rel", standby_o, 1'b1);
		tally_and_finish();
	end
	initial begin
		// Run needs about 140 us; leave ample margin
		#400_000;
		failures++;
		tally_and_finish();
	end
endmodule
